// [rtl/djp_pkg.sv]
// package: constants and carriers for the dual joystick port
package djp_pkg;
	localparam logic [7:0]  PORT_OFFSET      = 8'h00;
	localparam logic [7:0]  CFG_BASE_HIGH    = 8'h60;
	localparam logic [7:0]  CFG_BASE_LOW     = 8'h61;
	localparam logic [7:0]  CFG_ACTIVATE     = 8'h30;
	localparam logic [7:0]  CFG_POWER_CTRL   = 8'h22;
	localparam int          ACTIVATE_BIT     = 0;
	localparam int          POWER_BIT        = 2;
	localparam logic [7:0]  PORT_RESET       = 8'h00;
	localparam logic [15:0] BASE_RESET       = 16'h0000;
	localparam int          FIRST_X_BIT      = 0;
	localparam int          FIRST_Y_BIT      = 1;
	localparam int          SECOND_X_BIT     = 2;
	localparam int          SECOND_Y_BIT     = 3;
	localparam int          BUTTON_LSB       = 4;

	// one stick: timer outputs and buttons
	typedef struct packed {
		logic x_out;
		logic y_out;
		logic button_one;
		logic button_two;
	} djp_stick_t;

	// host i/o cycle
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} djp_io_t;

	// configuration cycle
	typedef struct packed {
		logic       wr;
		logic [7:0] index;
		logic [7:0] wdata;
	} djp_cfg_t;
endpackage

// [rtl/djp_sync.sv]
// module: three-stage synchroniser with agreement filter
module djp_sync (
	// clock, reset and enable
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic en_in,
	// data
	input  wire logic d_in,
	output logic      q_out
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q_out <= 1'b0;
		end else if (en_in) begin
			s1 <= d_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				q_out <= s3;
			end
		end
	end
endmodule

// [rtl/djp_top.sv]
// module: dual joystick port with base decode and rc timer control
module djp_top (
	// clock, reset, enable
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              clk_en_in,
	// host i/o cycle
	input  wire djp_pkg::djp_io_t  io_in,
	output logic [7:0]             io_rdata_out,
	output logic                   io_hit_out,
	// configuration cycle
	input  wire djp_pkg::djp_cfg_t cfg_in,
	output logic [7:0]             cfg_rdata_out,
	// stick pins
	input  wire djp_pkg::djp_stick_t first_stick_in,
	input  wire djp_pkg::djp_stick_t second_stick_in,
	input  wire logic [3:0]        threshold_in,
	output logic [3:0]             rc_timing_pins_out,
	output logic [3:0]             rc_timing_pins_oe_n_out
);
	logic       rst_meta;
	logic       rst_sync_n;
	logic [7:0] base_high;
	logic [7:0] base_low;
	logic       activate;
	logic       wr_prev;
	logic [3:0] rc_clear;
	logic [7:0] stick_port_snapshot;

	// reset release
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// raw inputs in port order
	wire [7:0] raw_bits = {second_stick_in.button_two, second_stick_in.button_one,
		first_stick_in.button_two, first_stick_in.button_one,
		second_stick_in.y_out, second_stick_in.x_out,
		first_stick_in.y_out, first_stick_in.x_out};
	wire [7:0] sync_bits;

	// synchronisers
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sync
			djp_sync u_sync (
				.clk_in   (clk_in),
				.rst_n_in (rst_sync_n),
				.en_in    (clk_en_in),
				.d_in     (raw_bits[gi]),
				.q_out    (sync_bits[gi])
			);
		end
	endgenerate

	// threshold synchronisers
	wire [3:0] thr_sync;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_thr
			djp_sync u_thr (
				.clk_in   (clk_in),
				.rst_n_in (rst_sync_n),
				.en_in    (clk_en_in),
				.d_in     (threshold_in[gi]),
				.q_out    (thr_sync[gi])
			);
		end
	endgenerate

	// address decode
	wire [15:0] base_addr = {base_high, base_low};
	wire addr_hit = activate && (io_in.addr == base_addr + {8'h00, djp_pkg::PORT_OFFSET});
	wire port_read = io_in.rd && addr_hit;
	wire port_write = io_in.wr && addr_hit;
	wire write_done = wr_prev && !port_write;
	wire cfg_act_wr = cfg_in.wr && (cfg_in.index == djp_pkg::CFG_ACTIVATE);
	wire cfg_pwr_wr = cfg_in.wr && (cfg_in.index == djp_pkg::CFG_POWER_CTRL);

	assign io_hit_out = port_read;

	// configuration registers
	always_ff @(posedge clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			base_high <= djp_pkg::BASE_RESET[15:8];
			base_low <= djp_pkg::BASE_RESET[7:0];
			activate <= 1'b0;
		end else if (clk_en_in) begin
			if (cfg_in.wr && cfg_in.index == djp_pkg::CFG_BASE_HIGH) begin
				base_high <= cfg_in.wdata;
			end
			if (cfg_in.wr && cfg_in.index == djp_pkg::CFG_BASE_LOW) begin
				base_low <= cfg_in.wdata;
			end
			if (cfg_act_wr) begin
				activate <= cfg_in.wdata[djp_pkg::ACTIVATE_BIT];
			end else if (cfg_pwr_wr) begin
				activate <= cfg_in.wdata[djp_pkg::POWER_BIT];
			end
		end
	end

	// configuration readback
	always_comb begin
		cfg_rdata_out = 8'h00;
		if (cfg_in.index == djp_pkg::CFG_BASE_HIGH) begin
			cfg_rdata_out = base_high;
		end else if (cfg_in.index == djp_pkg::CFG_BASE_LOW) begin
			cfg_rdata_out = base_low;
		end else if (cfg_in.index == djp_pkg::CFG_ACTIVATE) begin
			cfg_rdata_out[djp_pkg::ACTIVATE_BIT] = activate;
		end else if (cfg_in.index == djp_pkg::CFG_POWER_CTRL) begin
			cfg_rdata_out[djp_pkg::POWER_BIT] = activate;
		end
	end

	// rc pin control and snapshot
	always_ff @(posedge clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wr_prev <= 1'b0;
			rc_clear <= 4'h0;
			stick_port_snapshot <= djp_pkg::PORT_RESET;
			io_rdata_out <= 8'h00;
		end else if (clk_en_in) begin
			wr_prev <= port_write;
			if (write_done) begin
				rc_clear <= 4'hf;
			end else begin
				rc_clear <= rc_clear & ~thr_sync;
			end
			stick_port_snapshot <= {sync_bits[7:4], sync_bits[3:0] & rc_clear};
			io_rdata_out <= port_read ? stick_port_snapshot : 8'h00;
		end
	end

	// rc pins held low when not timing
	assign rc_timing_pins_out = 4'h0;
	assign rc_timing_pins_oe_n_out = rc_clear;
endmodule

// [bench/djp_stick_model.sv]
// model: rc charge and timer outputs behind each axis pin
module djp_stick_model (
	input  wire logic       clk_in,
	input  wire logic [3:0] oe_n_in,
	output logic [3:0]      thr_out,
	output logic [3:0]      tmr_out
);
	timeunit 1ns / 1ns;
	int lvl [4] = '{0, 0, 0, 0};
	always @(posedge clk_in)
		for (int i = 0; i < 4; i++)
			lvl[i] <= oe_n_in[i] ? lvl[i] + 1 : 0;
	always_comb
		for (int i = 0; i < 4; i++) begin
			thr_out[i] = lvl[i] >= 20 + 16 * i;
			tmr_out[i] = oe_n_in[i] && !thr_out[i];
		end
endmodule

// [bench/djp_props.sv]
// checker: decode, readback and timer pin properties
module djp_props (
	input wire logic clk_in, input wire logic rst_n_in,
	input wire djp_pkg::djp_io_t io_in, input wire logic [7:0] io_rdata_out,
	input wire logic io_hit_out, input wire djp_pkg::djp_cfg_t cfg_in,
	input wire logic [7:0] cfg_rdata_out, input wire logic [3:0] threshold_in,
	input wire logic [3:0] rc_timing_pins_out, input wire logic [3:0] rc_timing_pins_oe_n_out
);
	logic [15:0] base;
	logic        act;
	wire         wr_hit = io_in.wr && act && io_in.addr == base;
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in) {base, act} <= '0;
		else if (cfg_in.wr) case (cfg_in.index)
			8'h60: base[15:8] <= cfg_in.wdata;
			8'h61: base[7:0] <= cfg_in.wdata;
			8'h30: act <= cfg_in.wdata[0];
			8'h22: act <= cfg_in.wdata[2];
			default: ;
		endcase
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_pins_low: assert property (rc_timing_pins_out == 4'h0) else $error("pin high");
	a_hit_decode: assert property (io_hit_out == (io_in.rd && act && io_in.addr == base))
		else $error("decode");
	a_rdata_idle: assert property (!$past(io_hit_out) |-> io_rdata_out == 8'h00)
		else $error("stray data");
	a_write_rearm: assert property ($past(wr_hit) && !io_in.wr |->
		##[1:2] rc_timing_pins_oe_n_out == 4'hf) else $error("no rearm");
	a_no_early: assert property (wr_hit && $past(io_in.wr) && $past(io_in.wr, 2) |=>
		(rc_timing_pins_oe_n_out & ~$past(rc_timing_pins_oe_n_out)) == 4'h0) else $error("early");
	a_thr_clear: assert property ($rose(threshold_in[0]) |->
		##[2:6] !rc_timing_pins_oe_n_out[0]) else $error("no clear");
	a_cfg_base: assert property (cfg_in.index == 8'h60 |-> cfg_rdata_out == base[15:8])
		else $error("base");
	a_cfg_mirror: assert property (cfg_in.index == 8'h22 |-> cfg_rdata_out[2] == act)
		else $error("mirror");
	c_read: cover property (io_hit_out ##1 io_rdata_out != 8'h00);
	c_rearm: cover property (wr_hit ##1 !io_in.wr);
	c_clear: cover property ($rose(threshold_in[3]));
endmodule
bind djp_top djp_props i_djp_props (.*);

// [bench/dual_joystick_port_bench.sv]
// bench: dual joystick port register and timer tests
module dual_joystick_port_bench;
	timeunit 1ns / 1ns;
	logic              clk_in = 1'b0;
	logic              rst_n_in;
	djp_pkg::djp_io_t  io;
	djp_pkg::djp_cfg_t cfg;
	logic [7:0]        rd, crd;
	logic [3:0]        oe_n, pins, thr, tmr, btn;
	int                n_errors, checked;
	djp_top i_djp_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .io_in(io),
		.io_rdata_out(rd), .io_hit_out(), .cfg_in(cfg), .cfg_rdata_out(crd), .threshold_in(thr),
		.first_stick_in({tmr[0], tmr[1], btn[0], btn[1]}),
		.second_stick_in({tmr[2], tmr[3], btn[2], btn[3]}),
		.rc_timing_pins_out(pins), .rc_timing_pins_oe_n_out(oe_n));
	djp_stick_model i_djp_stick_model (.clk_in(clk_in), .oe_n_in(oe_n), .thr_out(thr),
		.tmr_out(tmr));
	task automatic check(input logic [7:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic io_rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk_in);
		io = '{1'b1, 1'b0, a, 8'h00};
		@(negedge clk_in);
		check(rd, e);
		io.rd = 1'b0;
	endtask
	task automatic io_wr(input logic [15:0] a);
		@(negedge clk_in);
		io = '{1'b0, 1'b1, a, 8'hff};
		repeat (3) @(negedge clk_in);
		check({4'h0, oe_n}, 8'h00);
		io.wr = 1'b0;
	endtask
	task automatic cfg_wr(input logic [7:0] i, d);
		@(negedge clk_in);
		cfg = '{1'b1, i, d};
		@(negedge clk_in);
		cfg.wr = 1'b0;
	endtask
	task automatic cfg_rd(input logic [7:0] i, m, e);
		cfg.index = i;
		#1 check(crd & m, e);
	endtask
	task automatic wrap_up;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial forever #5 clk_in = ~clk_in;
	initial begin
		#20000 n_errors++;
		wrap_up;
	end
	initial begin
		{io, cfg, btn, rst_n_in} = '0;
		repeat (3) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (3) @(negedge clk_in);
		cfg_rd(8'h60, 8'hff, 8'h00);
		io_rd(16'h0000, 8'h00);
		cfg_wr(8'h60, 8'h12);
		cfg_wr(8'h61, 8'h34);
		cfg_wr(8'h22, 8'h04);
		btn = 4'b1001;
		cfg_rd(8'h61, 8'hff, 8'h34);
		cfg_rd(8'h30, 8'h01, 8'h01);
		repeat (8) @(negedge clk_in);
		io_rd(16'h1234, 8'h90);
		io_rd(16'h1235, 8'h00);
		io_wr(16'h1234);
		repeat (8) @(negedge clk_in);
		io_rd(16'h1234, 8'h9f);
		repeat (19) @(negedge clk_in);
		io_rd(16'h1234, 8'h9e);
		repeat (70) @(negedge clk_in);
		io_rd(16'h1234, 8'h90);
		$display("decode and timer test done");
		cfg_wr(8'h30, 8'h00);
		cfg_rd(8'h22, 8'h04, 8'h00);
		io_rd(16'h1234, 8'h00);
		io_wr(16'h1234);
		repeat (4) @(negedge clk_in);
		check({oe_n, pins}, 8'h00);
		$display("activate test done");
		wrap_up;
	end
endmodule
